// ==== pps_pkg.sv ====
// constants, types and stage layout for the pipeline stall and protection control
package pps_pkg;

  localparam int PADDR_W = 22;
  localparam int DADDR_W = 32;
  localparam int WORD_W = 16;
  // register hazard mask: aux_pointer_full_regs (low halves alias), data page, stack pointer
  localparam int REG_N = 10;
  localparam int REG_DP_BIT = 8;
  localparam int REG_SP_BIT = 9;

  localparam int N_STAGES = 8;
  localparam int SV_F1 = 7;
  localparam int SV_F2 = 6;
  localparam int SV_D1 = 5;
  localparam int SV_D2 = 4;
  localparam int SV_R1 = 3;
  localparam int SV_R2 = 2;
  localparam int SV_E = 1;
  localparam int SV_W = 0;

  localparam int QDEPTH = 8;
  localparam int QPTR_W = 3;
  localparam int QCNT_W = 4;

  localparam int N_READY = 3;
  localparam int RDY_PROG = 0;
  localparam int RDY_DREAD = 1;
  localparam int RDY_DWRITE = 2;
  localparam int SYNC_STAGES = 3;
  localparam logic [N_READY-1:0] RDY_RESET = 3'h0;

  // writer slots checked against operand_address_stage: read addr, read data, execute
  localparam int N_PROT = 3;
  localparam int PROT_MAX_CYC = 3;

  localparam logic [PADDR_W-1:0] PC_RESET = 22'h00_0000;

  typedef enum logic [1:0] {
    FS_IDLE = 2'b00,
    FS_REQ = 2'b01,
    FS_WAIT = 2'b10
  } pps_fetch_e;

  typedef struct packed {
    logic valid;
    logic rd_en;
    logic [DADDR_W-1:0] rd_addr;
    logic wr_en;
    logic [DADDR_W-1:0] wr_addr;
    logic [REG_N-1:0] reg_rd;
    logic [REG_N-1:0] reg_wr;
  } pps_stage_s;

  localparam pps_stage_s STAGE_EMPTY = '0;

endpackage

// ==== pps_haz_if.sv ====
// hazard compare signals between the pipeline control and its checker
interface pps_haz_if;
  pps_pkg::pps_stage_s d2;
  pps_pkg::pps_stage_s wr_slot [pps_pkg::N_PROT];
  logic mem_hold;
  logic reg_hold;
  logic [1:0] hold_cyc;

  modport ctrl (
    output d2,
    output wr_slot,
    input mem_hold,
    input reg_hold,
    input hold_cyc
  );

  modport chk (
    input d2,
    input wr_slot,
    output mem_hold,
    output reg_hold,
    output hold_cyc
  );
endinterface

// ==== pps_hazard_check.sv ====
// write-then-read hazard detection for the operand_address_stage instruction
module pps_hazard_check (
  pps_haz_if.chk hz
);

  logic [pps_pkg::N_PROT-1:0] mem_hit;
  logic [pps_pkg::N_PROT-1:0] reg_hit;
  logic [pps_pkg::N_PROT-1:0] any_hit;

  // slot 0 is nearest: a writer there still needs the most cycles to land
  for (genvar i = 0; i < pps_pkg::N_PROT; i++) begin : g_slot
    assign mem_hit[i] = hz.d2.valid & hz.d2.rd_en & hz.wr_slot[i].valid &
                        hz.wr_slot[i].wr_en &
                        (hz.wr_slot[i].wr_addr == hz.d2.rd_addr);
    assign reg_hit[i] = hz.d2.valid & hz.wr_slot[i].valid &
                        (|(hz.wr_slot[i].reg_wr & hz.d2.reg_rd));
    assign any_hit[i] = mem_hit[i] | reg_hit[i];
  end

  assign hz.mem_hold = |mem_hit;
  assign hz.reg_hold = |reg_hit;

  always_comb begin
    hz.hold_cyc = 2'h0;
    for (int i = pps_pkg::N_PROT - 1; i >= 0; i--) begin
      if (any_hit[i]) begin
        hz.hold_cyc = 2'(pps_pkg::N_PROT - i);
      end
    end
  end

endmodule // pps_hazard_check

// ==== pps_pipe_ctrl.sv ====
// eight-stage pipeline stall, fetch queue and hazard protection control
module pps_pipe_ctrl (
  input wire logic clk,
  input wire logic resetn,
  input wire logic prog_ready_in,
  input wire logic dread_ready_in,
  input wire logic dwrite_ready_in,
  output logic prog_req,
  output logic [pps_pkg::PADDR_W-1:0] prog_addr,
  output logic prog_wide,
  input wire logic [2*pps_pkg::WORD_W-1:0] prog_rdata,
  input wire logic disc_req,
  input wire logic [pps_pkg::PADDR_W-1:0] disc_target,
  output logic [2*pps_pkg::WORD_W-1:0] queue_head,
  output logic [pps_pkg::QCNT_W-1:0] queue_count,
  input wire logic dec_len32,
  input wire logic dec_rd_en,
  input wire logic [pps_pkg::DADDR_W-1:0] dec_rd_addr,
  input wire logic dec_wr_en,
  input wire logic [pps_pkg::DADDR_W-1:0] dec_wr_addr,
  input wire logic [pps_pkg::REG_N-1:0] dec_reg_rd,
  input wire logic [pps_pkg::REG_N-1:0] dec_reg_wr,
  output logic d2_take,
  output logic dread_req,
  output logic [pps_pkg::DADDR_W-1:0] dread_addr,
  output logic dwrite_req,
  output logic [pps_pkg::DADDR_W-1:0] dwrite_addr,
  output logic reg_rd_strobe,
  output logic [pps_pkg::REG_N-1:0] reg_rd_mask,
  output logic reg_wr_strobe,
  output logic [pps_pkg::REG_N-1:0] reg_wr_mask,
  output logic [pps_pkg::N_STAGES-1:0] stage_valid,
  output logic front_stall,
  output logic back_stall,
  output logic starve_stall,
  output logic prot_stall,
  output logic [1:0] prot_cycles
);

  // ready synchronisers
  logic [pps_pkg::N_READY-1:0] rdy_s1_q;
  logic [pps_pkg::N_READY-1:0] rdy_s2_q;
  logic [pps_pkg::N_READY-1:0] rdy_s3_q;
  logic [pps_pkg::N_READY-1:0] rdy_q;
  logic [pps_pkg::N_READY-1:0] rdy_pin;

  // fetch side
  pps_pkg::pps_fetch_e fetch_st_q;
  logic [pps_pkg::PADDR_W-1:0] f1_addr_q;
  logic f1_wide_q;
  logic [pps_pkg::PADDR_W-1:0] next_pc_q;
  logic f2_valid_q;
  logic f2_wide_q;
  logic f2_odd_q;
  logic f1_busy;
  logic f1_done;
  logic f1_free;
  logic fetch_room;
  logic [pps_pkg::QCNT_W:0] words_committed;

  // queue
  logic [pps_pkg::WORD_W-1:0] q_mem [pps_pkg::QDEPTH];
  logic [pps_pkg::QPTR_W-1:0] q_wr_ptr_q;
  logic [pps_pkg::QPTR_W-1:0] q_rd_ptr_q;
  logic [pps_pkg::QCNT_W-1:0] q_cnt_q;
  logic [pps_pkg::QPTR_W-1:0] q_wr_ptr_nx;
  logic [pps_pkg::QPTR_W-1:0] q_rd_ptr_nx;
  logic push;
  logic [pps_pkg::QCNT_W-1:0] push_n;
  logic [pps_pkg::QCNT_W-1:0] pop_n;
  logic [pps_pkg::QCNT_W-1:0] need_n;
  logic [pps_pkg::WORD_W-1:0] push_lo;
  logic [pps_pkg::WORD_W-1:0] push_hi;
  logic inst_avail;

  // back half
  pps_pkg::pps_stage_s d2_q;
  pps_pkg::pps_stage_s r1_q;
  pps_pkg::pps_stage_s r2_q;
  pps_pkg::pps_stage_s e_q;
  pps_pkg::pps_stage_s w_q;
  pps_pkg::pps_stage_s dec_stage;
  logic back_frz;
  logic prot_hold;
  logic d2_go;
  logic d2_load;

  pps_haz_if hz ();

  // ---------------------------------------------------------------- sync
  assign rdy_pin[pps_pkg::RDY_PROG] = prog_ready_in;
  assign rdy_pin[pps_pkg::RDY_DREAD] = dread_ready_in;
  assign rdy_pin[pps_pkg::RDY_DWRITE] = dwrite_ready_in;

  // pins are asynchronous; a level is accepted once two late stages agree
  for (genvar i = 0; i < pps_pkg::N_READY; i++) begin : g_sync
    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
        rdy_s1_q[i] <= pps_pkg::RDY_RESET[i];
        rdy_s2_q[i] <= pps_pkg::RDY_RESET[i];
        rdy_s3_q[i] <= pps_pkg::RDY_RESET[i];
        rdy_q[i] <= pps_pkg::RDY_RESET[i];
      end else begin
        rdy_s1_q[i] <= rdy_pin[i];
        rdy_s2_q[i] <= rdy_s1_q[i];
        rdy_s3_q[i] <= rdy_s2_q[i];
        if (rdy_s2_q[i] == rdy_s3_q[i]) begin
          rdy_q[i] <= rdy_s3_q[i];
        end
      end
    end
  end

  // ---------------------------------------------------------------- fetch
  assign f1_busy = (fetch_st_q != pps_pkg::FS_IDLE);
  assign f1_done = f1_busy & rdy_q[pps_pkg::RDY_PROG];
  assign f1_free = !f1_busy | f1_done;

  // words already owed to the queue plus a full 32-bit fetch must still fit
  always_comb begin
    words_committed = {1'b0, q_cnt_q};
    if (f1_busy) begin
      words_committed = words_committed + (f1_wide_q ? 5'h02 : 5'h01);
    end
    if (f2_valid_q) begin
      words_committed = words_committed + (f2_wide_q ? 5'h02 : 5'h01);
    end
  end

  assign fetch_room = (words_committed + 5'h02) <= 5'(pps_pkg::QDEPTH);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      fetch_st_q <= pps_pkg::FS_IDLE;
      f1_addr_q <= pps_pkg::PC_RESET;
      f1_wide_q <= 1'b0;
      next_pc_q <= pps_pkg::PC_RESET;
    end else if (disc_req) begin
      fetch_st_q <= pps_pkg::FS_REQ;
      f1_addr_q <= disc_target;
      f1_wide_q <= !disc_target[0];
      next_pc_q <= disc_target + (disc_target[0] ? 22'h00_0001 : 22'h00_0002);
    end else if (f1_free && fetch_room) begin
      fetch_st_q <= pps_pkg::FS_REQ;
      f1_addr_q <= next_pc_q;
      f1_wide_q <= !next_pc_q[0];
      next_pc_q <= next_pc_q + (next_pc_q[0] ? 22'h00_0001 : 22'h00_0002);
    end else begin
      case (fetch_st_q)
        pps_pkg::FS_IDLE: begin
          fetch_st_q <= pps_pkg::FS_IDLE;
        end
        pps_pkg::FS_REQ, pps_pkg::FS_WAIT: begin
          // address held on the bus while the memory stretches the fetch
          if (f1_done) begin
            fetch_st_q <= pps_pkg::FS_IDLE;
          end else begin
            fetch_st_q <= pps_pkg::FS_WAIT;
          end
        end
        default: begin
          fetch_st_q <= pps_pkg::FS_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      f2_valid_q <= 1'b0;
      f2_wide_q <= 1'b0;
      f2_odd_q <= 1'b0;
    end else begin
      f2_valid_q <= f1_done & !disc_req;
      f2_wide_q <= f1_wide_q;
      f2_odd_q <= f1_addr_q[0];
    end
  end

  assign prog_req = f1_busy;
  assign prog_addr = f1_addr_q;
  assign prog_wide = f1_wide_q;

  // ---------------------------------------------------------------- queue
  // an odd fetch returns its word in the upper half of the aligned bus
  assign push = f2_valid_q & !disc_req;
  assign push_lo = f2_odd_q ? prog_rdata[31:16] : prog_rdata[15:0];
  assign push_hi = prog_rdata[31:16];
  assign push_n = push ? (f2_wide_q ? 4'h2 : 4'h1) : 4'h0;
  assign need_n = dec_len32 ? 4'h2 : 4'h1;
  assign pop_n = d2_load ? need_n : 4'h0;
  assign q_wr_ptr_nx = q_wr_ptr_q + 3'h1;
  assign q_rd_ptr_nx = q_rd_ptr_q + 3'h1;

  for (genvar i = 0; i < pps_pkg::QDEPTH; i++) begin : g_qent
    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
        q_mem[i] <= 16'h0000;
      end else if (push && (q_wr_ptr_q == 3'(i))) begin
        q_mem[i] <= push_lo;
      end else if (push && f2_wide_q && (q_wr_ptr_nx == 3'(i))) begin
        q_mem[i] <= push_hi;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      q_wr_ptr_q <= 3'h0;
      q_rd_ptr_q <= 3'h0;
      q_cnt_q <= 4'h0;
    end else if (disc_req) begin
      q_wr_ptr_q <= 3'h0;
      q_rd_ptr_q <= 3'h0;
      q_cnt_q <= 4'h0;
    end else begin
      q_wr_ptr_q <= q_wr_ptr_q + push_n[pps_pkg::QPTR_W-1:0];
      q_rd_ptr_q <= q_rd_ptr_q + pop_n[pps_pkg::QPTR_W-1:0];
      q_cnt_q <= q_cnt_q + push_n - pop_n;
    end
  end

  assign queue_head = {q_mem[q_rd_ptr_nx], q_mem[q_rd_ptr_q]};
  assign queue_count = q_cnt_q;

  // words in the queue have spent their queue-decode cycle already
  assign inst_avail = (q_cnt_q >= need_n) & !disc_req;

  // ---------------------------------------------------------------- back half
  assign back_frz = (r1_q.valid & r1_q.rd_en & !rdy_q[pps_pkg::RDY_DREAD]) |
                    (w_q.valid & w_q.wr_en & !rdy_q[pps_pkg::RDY_DWRITE]);

  assign hz.d2 = d2_q;
  assign hz.wr_slot[0] = r1_q;
  assign hz.wr_slot[1] = r2_q;
  assign hz.wr_slot[2] = e_q;

  pps_hazard_check u_hazard (
    .hz(hz.chk)
  );

  assign prot_hold = hz.mem_hold | hz.reg_hold;
  assign d2_go = d2_q.valid & !back_frz & !prot_hold;
  assign d2_load = !back_frz & (!d2_q.valid | d2_go) & inst_avail;

  always_comb begin
    dec_stage = pps_pkg::STAGE_EMPTY;
    dec_stage.valid = 1'b1;
    dec_stage.rd_en = dec_rd_en;
    dec_stage.rd_addr = dec_rd_addr;
    dec_stage.wr_en = dec_wr_en;
    dec_stage.wr_addr = dec_wr_addr;
    dec_stage.reg_rd = dec_reg_rd;
    dec_stage.reg_wr = dec_reg_wr;
  end

  // one register per stage; a freeze simply skips the update
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      d2_q <= pps_pkg::STAGE_EMPTY;
      r1_q <= pps_pkg::STAGE_EMPTY;
      r2_q <= pps_pkg::STAGE_EMPTY;
      e_q <= pps_pkg::STAGE_EMPTY;
      w_q <= pps_pkg::STAGE_EMPTY;
    end else if (!back_frz) begin
      w_q <= e_q;
      e_q <= r2_q;
      r2_q <= r1_q;
      // a protection hold sends a bubble down instead of a new operation
      r1_q <= d2_go ? d2_q : pps_pkg::STAGE_EMPTY;
      if (d2_load) begin
        d2_q <= dec_stage;
      end else if (d2_go) begin
        d2_q <= pps_pkg::STAGE_EMPTY;
      end
    end
  end

  // ---------------------------------------------------------------- outputs
  assign d2_take = d2_load;
  assign dread_req = r1_q.valid & r1_q.rd_en;
  assign dread_addr = r1_q.rd_addr;
  assign dwrite_req = w_q.valid & w_q.wr_en;
  assign dwrite_addr = w_q.wr_addr;

  // registers are touched only as an instruction leaves operand or execute
  assign reg_rd_strobe = d2_go & (|d2_q.reg_rd);
  assign reg_rd_mask = d2_q.reg_rd;
  assign reg_wr_strobe = e_q.valid & !back_frz & (|e_q.reg_wr);
  assign reg_wr_mask = e_q.reg_wr;

  assign stage_valid[pps_pkg::SV_F1] = f1_busy;
  assign stage_valid[pps_pkg::SV_F2] = f2_valid_q;
  assign stage_valid[pps_pkg::SV_D1] = (q_cnt_q != 4'h0);
  assign stage_valid[pps_pkg::SV_D2] = d2_q.valid;
  assign stage_valid[pps_pkg::SV_R1] = r1_q.valid;
  assign stage_valid[pps_pkg::SV_R2] = r2_q.valid;
  assign stage_valid[pps_pkg::SV_E] = e_q.valid;
  assign stage_valid[pps_pkg::SV_W] = w_q.valid;

  assign front_stall = f1_busy & !rdy_q[pps_pkg::RDY_PROG];
  assign back_stall = back_frz;
  assign starve_stall = !back_frz & !d2_q.valid & !inst_avail;
  assign prot_stall = !back_frz & prot_hold;
  assign prot_cycles = hz.hold_cyc;

endmodule // pps_pipe_ctrl

// ==== pps_pipe_ctrl_props.sv ====
// concurrent checks on the pipeline stall and protection control ports
module pps_pipe_ctrl_props (
  input wire logic clk,
  input wire logic resetn,
  input wire logic prog_ready_in,
  input wire logic prog_req,
  input wire logic [pps_pkg::PADDR_W-1:0] prog_addr,
  input wire logic prog_wide,
  input wire logic disc_req,
  input wire logic [pps_pkg::PADDR_W-1:0] disc_target,
  input wire logic [pps_pkg::QCNT_W-1:0] queue_count,
  input wire logic dec_len32,
  input wire logic d2_take,
  input wire logic dread_req,
  input wire logic [pps_pkg::DADDR_W-1:0] dread_addr,
  input wire logic reg_wr_strobe,
  input wire logic front_stall,
  input wire logic back_stall,
  input wire logic prot_stall,
  input wire logic [1:0] prot_cycles
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // five low samples: the ready synchroniser cannot have seen it high
  property p_fetch_hold;
    !prog_ready_in [*5] ##0 (prog_req && !disc_req) |=> $stable(prog_addr);
  endproperty
  a_fetch_hold: assert property (p_fetch_hold)
    else $error("fetch address moved while ready low");
  property p_fetch_flag;
    front_stall |-> prog_req;
  endproperty
  a_fetch_flag: assert property (p_fetch_flag)
    else $error("front stall without fetch request");
  property p_read_freeze;
    dread_req && back_stall |=> dread_req && $stable(dread_addr);
  endproperty
  a_read_freeze: assert property (p_read_freeze)
    else $error("frozen read request changed");
  property p_back_quiet;
    back_stall |-> !d2_take && !reg_wr_strobe;
  endproperty
  a_back_quiet: assert property (p_back_quiet)
    else $error("activity while back half frozen");
  property p_starve;
    (queue_count == 4'h0 || (dec_len32 && queue_count == 4'h1)) |-> !d2_take;
  endproperty
  a_starve: assert property (p_starve)
    else $error("incomplete instruction taken");
  property p_redirect;
    disc_req |-> !d2_take ##1 (queue_count == 4'h0 && prog_addr == $past(disc_target));
  endproperty
  a_redirect: assert property (p_redirect)
    else $error("redirect did not flush and retarget");
  property p_odd_narrow;
    prog_req |-> prog_wide == !prog_addr[0];
  endproperty
  a_odd_narrow: assert property (p_odd_narrow)
    else $error("fetch width does not match address parity");
  property p_prot_count;
    prot_stall && prot_cycles == 2'h3 && !back_stall |=> prot_stall && prot_cycles == 2'h2;
  endproperty
  a_prot_count: assert property (p_prot_count)
    else $error("protection count did not step down");
  property p_prot_hold;
    prot_stall |-> prot_cycles != 2'h0 && !d2_take;
  endproperty
  a_prot_hold: assert property (p_prot_hold)
    else $error("protection hold inconsistent");
endmodule // pps_pipe_ctrl_props

bind pps_pipe_ctrl pps_pipe_ctrl_props pps_pipe_ctrl_props_inst (.clk, .resetn, .prog_ready_in,
  .prog_req, .prog_addr, .prog_wide, .disc_req, .disc_target, .queue_count, .dec_len32,
  .d2_take, .dread_req, .dread_addr, .reg_wr_strobe, .front_stall, .back_stall, .prot_stall,
  .prot_cycles);

// ==== pps_mem_model.sv ====
// behavioural program memory and ready-line model
module pps_mem_model (
  input wire logic clk,
  input wire logic resetn,
  input wire logic prog_req,
  input wire logic [21:0] prog_addr,
  input wire logic prog_wide,
  input wire logic [2:0] slow,
  output logic [31:0] prog_rdata,
  output logic prog_ready_in,
  output logic dread_ready_in,
  output logic dwrite_ready_in
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [21:0] addr_q;
  logic wide_q;
  logic live_q;
  logic [15:0] junk_q;
  function automatic logic [15:0] word_at(input logic [21:0] a);
    return {a[7:0], a[15:8]} ^ 16'hC3A5;
  endfunction
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      live_q <= 1'b0;
      addr_q <= '0;
      wide_q <= 1'b0;
      junk_q <= 16'h0001;
    end else begin
      live_q <= prog_req;
      addr_q <= prog_addr;
      wide_q <= prog_wide;
      junk_q <= {junk_q[14:0], ~junk_q[15]};
    end
  end
  // undriven bus: moving pattern so stale data never passes
  always_comb begin
    if (!live_q) prog_rdata = {junk_q, ~junk_q};
    else if (wide_q) prog_rdata = {word_at(addr_q + 22'h1), word_at(addr_q)};
    else prog_rdata = {word_at(addr_q), ~word_at(addr_q)};
  end
  assign prog_ready_in = !slow[0];
  assign dread_ready_in = !slow[1];
  assign dwrite_ready_in = !slow[2];
endmodule // pps_mem_model

// ==== testbench.sv ====
// self-checking bench for the pipeline stall and protection control
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [2:0] slow = 3'h0;
  logic disc_req = 1'b0;
  logic [21:0] disc_target = '0;
  logic dec_len32 = 1'b0;
  logic dec_rd_en = 1'b0;
  logic [31:0] dec_rd_addr = '0;
  logic dec_wr_en = 1'b0;
  logic [31:0] dec_wr_addr = '0;
  logic [9:0] dec_reg_rd = '0;
  logic [9:0] dec_reg_wr = '0;
  logic prog_ready_in, dread_ready_in, dwrite_ready_in, prog_req, prog_wide, d2_take;
  logic dread_req, dwrite_req, reg_rd_strobe, reg_wr_strobe;
  logic front_stall, back_stall, starve_stall, prot_stall;
  logic [21:0] prog_addr;
  logic [31:0] prog_rdata, queue_head, dread_addr, dwrite_addr;
  logic [3:0] queue_count;
  logic [9:0] reg_rd_mask, reg_wr_mask;
  logic [7:0] stage_valid;
  logic [1:0] prot_cycles;
  int bad_count = 0;
  int n_checks = 0;
  logic [22:0] exp_q[$];
  logic [15:0] lfsr = 16'h505A;

  pps_pipe_ctrl pps_pipe_ctrl_inst (.*);
  pps_mem_model pps_mem_model_inst (.*);

  always #5 clk = ~clk;

  function automatic logic [15:0] exp_word(input logic [21:0] a);
    return {a[7:0], a[15:8]} ^ 16'hC3A5;
  endfunction
  function automatic logic [15:0] next_rand();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr;
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // expectations are reloaded at the redirect, before any new take can land
  task automatic redirect(input logic [21:0] t, input logic len32);
    cyc(1);
    disc_req = 1'b1;
    disc_target = t;
    dec_len32 = len32;
    exp_q.delete();
    for (int i = 0; i < 40; i++) exp_q.push_back({len32, t + 22'(len32 ? 2 * i : i)});
    cyc(1);
    disc_req = 1'b0;
  endtask
  // spacing between the third and fourth take after a redirect
  task automatic take_gap(output int g);
    int k, last;
    k = 0;
    last = 0;
    g = -1;
    for (int n = 0; n < 200 && k < 4; n++) begin
      @(negedge clk);
      if (d2_take === 1'b1) begin
        k++;
        g = n - last;
        last = n;
      end
    end
    if (k < 4) g = -1;
  endtask

  always @(negedge clk) begin : monitor
    logic [22:0] e;
    if (resetn && d2_take === 1'b1 && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      if (e[22]) check(queue_head, {exp_word(e[21:0] + 22'h1), exp_word(e[21:0])});
      else check({16'h0, queue_head[15:0]}, {16'h0, exp_word(e[21:0])});
    end
  end

  initial begin
    int g;
    for (int i = 0; i < 40; i++) exp_q.push_back({1'b0, 22'(i)});
    repeat (3) @(negedge clk);
    check({24'h0, stage_valid}, 32'h0);
    check({31'h0, prog_req}, 32'h0);
    cyc(2);
    resetn = 1'b1;
    cyc(30);
    check({27'h0, stage_valid[4:0]}, 32'h1F);
    dec_rd_en = 1'b1;
    dec_wr_en = 1'b1;
    dec_rd_addr = 32'h100;
    dec_wr_addr = 32'h200;
    void'(next_rand());
    redirect({6'h0, lfsr[15:1], 1'b0}, 1'b0);
    for (int i = 0; i < 60; i++) begin
      void'(next_rand());
      slow = lfsr[2:0] & lfsr[5:3];
      cyc(4);
    end
    slow = 3'h0;
    cyc(20);
    $display("test stream done");
    for (int r = 0; r < 3; r++) begin
      slow = 3'(1 << r);
      cyc(14);
      check({30'h0, front_stall, back_stall}, r == 0 ? 32'h2 : 32'h1);
      // the frozen read or write must keep its request and address on the bus
      if (r > 0) check({31'h0, r == 1 ? dread_req : dwrite_req}, 32'h1);
      if (r > 0) check(r == 1 ? dread_addr : dwrite_addr, r == 1 ? 32'h100 : 32'h200);
      slow = 3'h0;
      cyc(14);
    end
    $display("test waits done");
    dec_rd_en = 1'b0;
    dec_wr_en = 1'b0;
    void'(next_rand());
    redirect({6'h0, lfsr[15:1], 1'b1}, 1'b1);
    check({10'h0, prog_addr}, {10'h0, 6'h0, lfsr[15:1], 1'b1});
    check({31'h0, prog_wide}, 32'h0);
    check({31'h0, starve_stall}, 32'h1);
    cyc(40);
    $display("test odd redirect done");
    for (int r = 0; r < 12; r++) begin
      dec_rd_en = (r < 2);
      dec_wr_en = (r < 2);
      dec_rd_addr = 32'h40;
      dec_wr_addr = (r == 0) ? 32'h40 : 32'h44;
      dec_reg_wr = (r >= 2) ? 10'(1 << (r - 2)) : 10'h0;
      dec_reg_rd = dec_reg_wr;
      void'(next_rand());
      redirect({6'h0, lfsr[15:1], 1'b0}, 1'b0);
      take_gap(g);
      check(32'(g), (r == 1) ? 32'h1 : 32'(1 + pps_pkg::PROT_MAX_CYC));
    end
    $display("test hazards done");
    tally_and_finish();
  end

  initial begin
    #200000;
    bad_count++;
    $display("mismatch at %0t: run timed out", $time);
    tally_and_finish();
  end
endmodule // testbench
